// ### dirm_top.sv
// Channel 5 progress index, data path and peripheral request multiplexer
//
// Behaviour
// (R1) A 16-bit read-only index counts the items the channel has already copied.
// (R2) After a non-circular transfer ends and the enable clears, the index holds the length.
// (R3) Starting a new non-circular transfer clears the index to zero.
// (R4) In circular operation the index returns to zero each time the channel wraps.
// (R5) Selector bits 11:8, reset 0xF, map a peripheral pair onto channels 4 and 5.
// (R6) Selector bits 7:4, reset 0xF, map a peripheral pair onto channels 2 and 3.
// (R7) Selector bits 3:0, reset 0xF, map a peripheral pair onto channels 0 and 1.
// (R8) A secure channel 5 has request-triggered mode forced off and ignores requests.
// (R9) In each pair the receive request feeds the even channel, the transmit the odd one.
// (R10) Selector values 0x0, 0x1 and 0x2 pick the SPI, first UART and second UART pairs.
// (R11) Values 0x3 to 0xE pick the further peripherals and 0xF picks none.
// (R12) When two selectors match, the lower-numbered one drives the acknowledges.
// (R13) In request-triggered mode the channel waits for its request, else it runs at once.
// (R14) In circular operation the enable never clears by itself.
// (R15) The index steps by one in the cycle an item has been both read and written.
`timescale 1ns/100ps
`default_nettype none
module dirm_top #(
   parameter int DATA_W     = 32,
   parameter int FIFO_DEPTH = 8
) (
   input  wire logic                          core_clk,
   input  wire logic                          rstn,
   input  wire logic [31:0]                   awaddr,
   input  wire logic                          awvalid,
   output logic                               awready,
   input  wire logic [31:0]                   wdata,
   input  wire logic [3:0]                    wstrb,
   input  wire logic                          wvalid,
   output logic                               wready,
   output logic [1:0]                         bresp,
   output logic                               bvalid,
   input  wire logic                          bready,
   input  wire logic [31:0]                   araddr,
   input  wire logic                          arvalid,
   output logic                               arready,
   output logic [31:0]                        rdata,
   output logic [1:0]                         rresp,
   output logic                               rvalid,
   input  wire logic                          rready,
   input  wire logic [dirm_pkg::NUM_PERIPH-1:0] perRxReq,
   input  wire logic [dirm_pkg::NUM_PERIPH-1:0] perTxReq,
   output logic [dirm_pkg::NUM_PERIPH-1:0]    perRxAck,
   output logic [dirm_pkg::NUM_PERIPH-1:0]    perTxAck,
   input  wire logic [4:0]                    chAck,
   output logic [4:0]                         chReq,
   input  wire logic                          srcValid,
   input  wire logic [DATA_W-1:0]             srcData,
   output logic                               srcReady,
   output logic                               dstValid,
   output logic [DATA_W-1:0]                  dstData,
   input  wire logic                          dstReady
);
   localparam int IW = dirm_pkg::IDX_W;
   localparam int LW = $clog2(FIFO_DEPTH + 2);

   typedef struct packed {
      logic                                 awRdy;
      logic                                 awTaken;
      logic [31:0]                          awAddr;
      logic                                 wRdy;
      logic                                 wTaken;
      logic [31:0]                          wData;
      logic [3:0]                           wStrb;
      logic                                 bValid;
      logic [1:0]                           bResp;
      logic                                 arRdy;
      logic                                 rValid;
      logic [31:0]                          rData;
      logic [1:0]                           rResp;
      logic [11:0]                          sel;
      logic                                 ctrlOn;
      logic                                 ctrlCirc;
      logic                                 ctrlSecure;
      logic                                 ctrlMode;
      logic [IW-1:0]                        len;
      logic [IW-1:0]                        idx;
      logic [IW-1:0]                        rdCnt;
      dirm_pkg::dirm_state_t                state;
      logic                                 srcRdy;
      logic [5:0]                           req;
      logic [dirm_pkg::NUM_PERIPH-1:0]      rxAck;
      logic [dirm_pkg::NUM_PERIPH-1:0]      txAck;
   } dirm_st_t;

   dirm_st_t q_ff;
   dirm_st_t nxt_q;

   logic          fifoInRdy;
   logic [LW-1:0] fifoLevel;
   logic          push;
   logic          pop;
   logic          effMode;
   logic          lastItem;
   logic          swStart;
   logic [5:0]    ackAll;

   dirm_fifo #(
      .W     (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk (core_clk),
      .rstn     (rstn),
      .inValid  (push),
      .inData   (srcData),
      .inReady  (fifoInRdy),
      .outValid (dstValid),
      .outData  (dstData),
      .outReady (dstReady),
      .level    (fifoLevel)
   );

   assign push     = srcValid && q_ff.srcRdy;
   assign pop      = dstValid && dstReady;
   assign effMode  = q_ff.ctrlMode && !q_ff.ctrlSecure;                      // [R8]
   assign lastItem = pop && ((q_ff.idx + IW'(1)) == q_ff.len);
   assign swStart  = q_ff.awTaken && q_ff.wTaken && !q_ff.bValid && q_ff.wStrb[0]
                     && (dirm_pkg::dirm_decode(q_ff.awAddr) == dirm_pkg::REG_CTRL)
                     && q_ff.wData[dirm_pkg::CTRL_ON_BIT] && !q_ff.ctrlOn;
   assign ackAll   = {push && effMode, chAck};

   always_comb begin
      logic [3:0]  s;
      logic [31:0] m;
      s = '0;
      m = '0;
      nxt_q = q_ff;

      // Request multiplexer: rx to the even channel, tx to the odd one
      for (int k = 0; k < dirm_pkg::NUM_PAIRS; k++) begin
         s = q_ff.sel[dirm_pkg::SEL_W*k +: dirm_pkg::SEL_W];
         nxt_q.req[2*k]   = (s != dirm_pkg::SEL_NONE) && perRxReq[s];          // [R9] [R10] [R11]
         nxt_q.req[2*k+1] = (s != dirm_pkg::SEL_NONE) && perTxReq[s];          // [R9] [R10] [R11]
      end
      // Acknowledge routing, lowest pair written last so it wins
      nxt_q.rxAck = '0;
      nxt_q.txAck = '0;
      for (int k = dirm_pkg::NUM_PAIRS - 1; k >= 0; k--) begin
         s = q_ff.sel[dirm_pkg::SEL_W*k +: dirm_pkg::SEL_W];
         if (s != dirm_pkg::SEL_NONE) begin
            nxt_q.rxAck[s] = ackAll[2*k];                                      // [R12]
            nxt_q.txAck[s] = ackAll[2*k+1];                                    // [R12]
         end
      end

      // Channel 5 progress
      if (push) begin
         nxt_q.rdCnt = q_ff.rdCnt + IW'(1);
         if (q_ff.ctrlCirc && (nxt_q.rdCnt == q_ff.len)) begin
            nxt_q.rdCnt = '0;
         end
      end
      if (pop && q_ff.state == dirm_pkg::ST_RUN) begin
         if (lastItem && q_ff.ctrlCirc) begin
            nxt_q.idx = '0;                                                    // [R4] [R14]
         end else if (lastItem) begin
            nxt_q.idx = q_ff.len;                                              // [R2]
            nxt_q.ctrlOn = 1'b0;
            nxt_q.state = dirm_pkg::ST_IDLE;
         end else begin
            nxt_q.idx = q_ff.idx + IW'(1);                                     // [R15] [R1]
         end
      end

      // Write channel
      if (awvalid && q_ff.awRdy) begin
         nxt_q.awTaken = 1'b1;
         nxt_q.awAddr = awaddr;
      end
      if (wvalid && q_ff.wRdy) begin
         nxt_q.wTaken = 1'b1;
         nxt_q.wData = wdata;
         nxt_q.wStrb = wstrb;
      end
      if (q_ff.bValid && bready) begin
         nxt_q.bValid = 1'b0;
      end
      if (q_ff.awTaken && q_ff.wTaken && !q_ff.bValid) begin
         nxt_q.awTaken = 1'b0;
         nxt_q.wTaken = 1'b0;
         nxt_q.bValid = 1'b1;
         nxt_q.bResp = dirm_pkg::RESP_OKAY;
         case (dirm_pkg::dirm_decode(q_ff.awAddr))
            dirm_pkg::REG_MUX: begin
               m = dirm_pkg::dirm_merge({20'h00000, q_ff.sel}, q_ff.wData, q_ff.wStrb);
               nxt_q.sel = m[11:0];
            end
            dirm_pkg::REG_LEN: begin
               m = dirm_pkg::dirm_merge({16'h0000, q_ff.len}, q_ff.wData, q_ff.wStrb);
               nxt_q.len = m[IW-1:0];
            end
            dirm_pkg::REG_CTRL: begin
               if (q_ff.wStrb[0]) begin
                  nxt_q.ctrlCirc = q_ff.wData[dirm_pkg::CTRL_CIRC_BIT];
                  nxt_q.ctrlSecure = q_ff.wData[dirm_pkg::CTRL_SECURE_BIT];
                  nxt_q.ctrlMode = q_ff.wData[dirm_pkg::CTRL_MODE_BIT];
                  if (swStart) begin
                     nxt_q.ctrlOn = 1'b1;
                     nxt_q.state = dirm_pkg::ST_RUN;
                     nxt_q.idx = '0;                                           // [R3]
                     nxt_q.rdCnt = '0;
                  end else if (!q_ff.wData[dirm_pkg::CTRL_ON_BIT]) begin
                     nxt_q.ctrlOn = 1'b0;
                     nxt_q.state = dirm_pkg::ST_IDLE;
                  end
               end
            end
            dirm_pkg::REG_IDX: begin
               nxt_q.bResp = dirm_pkg::RESP_OKAY;                              // [R1]
            end
            default: begin
               nxt_q.bResp = dirm_pkg::RESP_SLVERR;
            end
         endcase
      end
      nxt_q.awRdy = !nxt_q.awTaken && !nxt_q.bValid;
      nxt_q.wRdy = !nxt_q.wTaken && !nxt_q.bValid;

      // Read channel
      if (q_ff.rValid && rready) begin
         nxt_q.rValid = 1'b0;
      end
      if (arvalid && q_ff.arRdy) begin
         nxt_q.rValid = 1'b1;
         nxt_q.rResp = dirm_pkg::RESP_OKAY;
         nxt_q.rData = '0;
         case (dirm_pkg::dirm_decode(araddr))
            dirm_pkg::REG_IDX:  nxt_q.rData[IW-1:0] = q_ff.idx;                // [R1]
            dirm_pkg::REG_MUX:  nxt_q.rData[11:0] = q_ff.sel;
            dirm_pkg::REG_LEN:  nxt_q.rData[IW-1:0] = q_ff.len;
            dirm_pkg::REG_CTRL: begin
               nxt_q.rData[dirm_pkg::CTRL_ON_BIT] = q_ff.ctrlOn;
               nxt_q.rData[dirm_pkg::CTRL_CIRC_BIT] = q_ff.ctrlCirc;
               nxt_q.rData[dirm_pkg::CTRL_SECURE_BIT] = q_ff.ctrlSecure;
               nxt_q.rData[dirm_pkg::CTRL_MODE_BIT] = effMode;
            end
            default: nxt_q.rResp = dirm_pkg::RESP_SLVERR;
         endcase
      end
      nxt_q.arRdy = !nxt_q.rValid;

      // Source may be taken only with room, a pending item and, in request mode, a request
      nxt_q.srcRdy = (nxt_q.state == dirm_pkg::ST_RUN) && nxt_q.ctrlOn
                     && (!(nxt_q.ctrlMode && !nxt_q.ctrlSecure) || nxt_q.req[5]) // [R13] [R8]
                     && (nxt_q.ctrlCirc || (nxt_q.rdCnt < nxt_q.len))
                     && fifoInRdy
                     && ((32'(fifoLevel) + 32'(push)) < FIFO_DEPTH);
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         q_ff <= '0;
         q_ff.sel <= {dirm_pkg::SEL_RESET, dirm_pkg::SEL_RESET, dirm_pkg::SEL_RESET}; // [R5] [R6] [R7]
         q_ff.idx <= dirm_pkg::IDX_RESET;
         q_ff.len <= dirm_pkg::LEN_RESET;
         q_ff.state <= dirm_pkg::ST_IDLE;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign awready  = q_ff.awRdy;
   assign wready   = q_ff.wRdy;
   assign bvalid   = q_ff.bValid;
   assign bresp    = q_ff.bResp;
   assign arready  = q_ff.arRdy;
   assign rvalid   = q_ff.rValid;
   assign rdata    = q_ff.rData;
   assign rresp    = q_ff.rResp;
   assign chReq    = q_ff.req[4:0];
   assign perRxAck = q_ff.rxAck;
   assign perTxAck = q_ff.txAck;
   assign srcReady = q_ff.srcRdy;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   sequence lastNonCirc;
      lastItem && q_ff.state == dirm_pkg::ST_RUN && !q_ff.ctrlCirc;
   endsequence
   sequence lastCirc;
      lastItem && q_ff.state == dirm_pkg::ST_RUN && q_ff.ctrlCirc;
   endsequence

   a_idx_step: assert property (pop && !lastItem && q_ff.state == dirm_pkg::ST_RUN // [R15]
      && !swStart |=> q_ff.idx == $past(q_ff.idx) + IW'(1)) else $error("index did not step");
   a_idx_final_hold: assert property (lastNonCirc ##1 (!swStart)[*2] // [R2]
      |-> q_ff.idx == $past(q_ff.len, 2) && !q_ff.ctrlOn) else $error("final index lost");
   a_idx_start_clr: assert property (swStart |=> q_ff.idx == '0 && q_ff.ctrlOn) // [R3]
      else $error("start did not clear index");
   a_circ_wrap: assert property (lastCirc and !swStart // [R4] [R14]
      |=> q_ff.idx == '0 && q_ff.ctrlOn) else $error("circular wrap wrong");
   a_mux_pair01: assert property (q_ff.sel[3:0] != dirm_pkg::SEL_NONE // [R7] [R9] [R10]
      |=> chReq[0] == $past(perRxReq[q_ff.sel[3:0]]) && chReq[1] == $past(perTxReq[q_ff.sel[3:0]]))
      else $error("pair 0/1 routing wrong");
   a_mux_pair23: assert property (q_ff.sel[7:4] != dirm_pkg::SEL_NONE // [R6] [R9]
      |=> chReq[2] == $past(perRxReq[q_ff.sel[7:4]]) && chReq[3] == $past(perTxReq[q_ff.sel[7:4]]))
      else $error("pair 2/3 routing wrong");
   a_mux_pair4: assert property (q_ff.sel[11:8] == dirm_pkg::SEL_NONE |=> !chReq[4]) // [R5] [R11]
      else $error("none selection drove a request");
   a_ack_priority: assert property (q_ff.sel[3:0] == q_ff.sel[7:4] // [R12]
      && q_ff.sel[3:0] != dirm_pkg::SEL_NONE
      |=> perRxAck[$past(q_ff.sel[3:0])] == $past(chAck[0])) else $error("ack priority wrong");
   a_req_wait: assert property (nxt_q.ctrlMode && !nxt_q.ctrlSecure && !nxt_q.req[5] // [R13]
      |=> !srcReady) else $error("moved data without request");
   a_sec_no_ack: assert property (q_ff.ctrlSecure && push // [R8]
      && q_ff.sel[11:8] != dirm_pkg::SEL_NONE && q_ff.sel[11:8] != q_ff.sel[3:0]
      && q_ff.sel[11:8] != q_ff.sel[7:4] |=> !perTxAck[$past(q_ff.sel[11:8])])
      else $error("secure channel acknowledged");
   a_ch5_ack: assert property (effMode && push // [R9] [R12]
      && q_ff.sel[11:8] != dirm_pkg::SEL_NONE && q_ff.sel[11:8] != q_ff.sel[3:0]
      && q_ff.sel[11:8] != q_ff.sel[7:4] |=> perTxAck[$past(q_ff.sel[11:8])])
      else $error("channel 5 acknowledge lost");
endmodule
`default_nettype wire

// ### dirm_pkg.sv
// Package of constants and types for the DMA index counter and request multiplexer
package dirm_pkg;

   // Register byte addresses
   localparam logic [31:0] ADDR_LEN  = 32'h500602AC;
   localparam logic [31:0] ADDR_CTRL = 32'h500602B0;
   localparam logic [31:0] ADDR_IDX  = 32'h500602B4;
   localparam logic [31:0] ADDR_MUX  = 32'h50060300;

   // Widths and field layout
   localparam int          IDX_W      = 16;
   localparam int          SEL_W      = 4;
   localparam int          NUM_PAIRS  = 3;
   localparam int          NUM_PERIPH = 15;
   localparam int          SEL01_LSB  = 0;
   localparam int          SEL23_LSB  = 4;
   localparam int          SEL45_LSB  = 8;
   localparam logic [3:0]  SEL_RESET  = 4'hF;
   localparam logic [3:0]  SEL_NONE   = 4'hF;
   localparam logic [15:0] IDX_RESET  = 16'h0000;
   localparam logic [15:0] LEN_RESET  = 16'h0000;

   // Control register bits
   localparam int CTRL_ON_BIT     = 0;
   localparam int CTRL_CIRC_BIT   = 1;
   localparam int CTRL_SECURE_BIT = 2;
   localparam int CTRL_MODE_BIT   = 3;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      REG_LEN  = 3'b000,
      REG_CTRL = 3'b001,
      REG_IDX  = 3'b010,
      REG_MUX  = 3'b011,
      REG_NONE = 3'b100
   } dirm_reg_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN  = 1'b1
   } dirm_state_t;

   function automatic dirm_reg_t dirm_decode(input logic [31:0] addr);
      case (addr)
         ADDR_LEN:  dirm_decode = REG_LEN;
         ADDR_CTRL: dirm_decode = REG_CTRL;
         ADDR_IDX:  dirm_decode = REG_IDX;
         ADDR_MUX:  dirm_decode = REG_MUX;
         default:   dirm_decode = REG_NONE;
      endcase
   endfunction

   function automatic logic [31:0] dirm_merge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
      for (int b = 0; b < 4; b++) begin
         dirm_merge[8*b +: 8] = strb[b] ? data[8*b +: 8] : old[8*b +: 8];
      end
   endfunction

endpackage

// ### dirm_fifo.sv
// Data FIFO with registered output stage
`timescale 1ns/100ps
`default_nettype none
module dirm_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 8
) (
   input  wire logic                         core_clk,
   input  wire logic                         rstn,
   input  wire logic                         inValid,
   input  wire logic [W-1:0]                 inData,
   output logic                              inReady,
   output logic                              outValid,
   output logic [W-1:0]                      outData,
   input  wire logic                         outReady,
   output logic [$clog2(DEPTH+2)-1:0]        level
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 2);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [CW-1:0]           cnt;
      logic                    oValid;
      logic [W-1:0]            oData;
   } dirm_fifo_st_t;

   dirm_fifo_st_t q_ff;
   dirm_fifo_st_t nxt_q;

   always_comb begin
      nxt_q = q_ff;
      if (inValid && (q_ff.cnt < CW'(DEPTH))) begin
         nxt_q.mem[q_ff.wp] = inData;
         nxt_q.wp = (q_ff.wp == AW'(DEPTH - 1)) ? '0 : q_ff.wp + AW'(1);
         nxt_q.cnt = nxt_q.cnt + CW'(1);
      end
      if (q_ff.oValid && outReady) begin
         nxt_q.oValid = 1'b0;
      end
      // Refill the output stage from memory when it empties
      if ((!q_ff.oValid || outReady) && (q_ff.cnt != '0)) begin
         nxt_q.oData = q_ff.mem[q_ff.rp];
         nxt_q.oValid = 1'b1;
         nxt_q.rp = (q_ff.rp == AW'(DEPTH - 1)) ? '0 : q_ff.rp + AW'(1);
         nxt_q.cnt = nxt_q.cnt - CW'(1);
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign inReady  = q_ff.cnt < CW'(DEPTH);
   assign outValid = q_ff.oValid;
   assign outData  = q_ff.oData;
   assign level    = q_ff.cnt + CW'(q_ff.oValid);
endmodule
`default_nettype wire

// ### dirm_periph_model.sv
// Peripheral-side model: item source and item sink of channel 5
`timescale 1ns/100ps
`default_nettype none
module dirm_periph_model #(
   parameter logic [31:0] SEED = 32'h00001F3D
) (
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic        addStb,
   input  wire logic [7:0]  addCnt,
   input  wire logic        sinkOn,
   input  wire logic        stallOn,
   output logic             srcValid,
   output logic [31:0]      srcData,
   input  wire logic        srcReady,
   input  wire logic        dstValid,
   input  wire logic [31:0] dstData,
   output logic             dstReady
);
   logic [31:0] sentQ[$];
   logic [31:0] gotQ[$];
   logic [31:0] lfsr;
   int          left;

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         srcValid <= 1'b0;
         srcData <= 32'h00000000;
         dstReady <= 1'b0;
         lfsr = SEED;
         left = 0;
      end else begin
         lfsr ^= lfsr << 13;
         lfsr ^= lfsr >> 17;
         lfsr ^= lfsr << 5;
         if (srcValid && srcReady) begin
            sentQ.push_back(srcData);
            left--;
         end
         if (addStb) begin
            left += addCnt;
         end
         // An offered item is held until taken; idle data toggles every cycle
         if (!srcValid || srcReady) begin
            if (left > 0 && (!stallOn || lfsr[0])) begin
               srcValid <= 1'b1;
               srcData <= lfsr;
            end else begin
               srcValid <= 1'b0;
               srcData <= ~srcData;
            end
         end
         if (dstValid && dstReady) begin
            gotQ.push_back(dstData);
         end
         dstReady <= sinkOn && (!stallOn || lfsr[1]);
      end
   end
endmodule
`default_nettype wire

// ### dirm_top_tb.sv
// Self-checking bench of the channel 5 index and the request multiplexer
`timescale 1ns/100ps
`default_nettype none
module dirm_top_tb;
   localparam logic [31:0] A_LEN = dirm_pkg::ADDR_LEN;
   localparam logic [31:0] A_CTL = dirm_pkg::ADDR_CTRL;
   localparam logic [31:0] A_IDX = dirm_pkg::ADDR_IDX;
   localparam logic [31:0] A_MUX = dirm_pkg::ADDR_MUX;
   localparam logic [31:0] A_BAD = 32'h50060304;
   logic        core_clk = 1'b0;
   logic        rstn = 1'b0;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, srcData, dstData, rd, r;
   logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1;
   logic        rready = 1'b1, awready, wready, bvalid, arready, rvalid;
   logic [3:0]  wstrb = 4'hF;
   logic [1:0]  bresp, rresp, rsp;
   logic [14:0] perRxReq = '0, perTxReq = '0, perRxAck, perTxAck;
   logic [4:0]  chAck = '0, chReq;
   logic        srcValid, srcReady, dstValid, dstReady;
   logic        addStb = 1'b0, sinkOn = 1'b0, stallOn = 1'b0;
   logic [7:0]  addCnt = '0;
   logic [11:0] s;
   logic [3:0]  v;
   logic [31:0] seed = 32'h000061D1;
   int          failCount = 0;
   int          cmpCount = 0;
   int          cyc = 0;

   dirm_top DUT (.core_clk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .perRxReq, .perTxReq, .perRxAck, .perTxAck, .chAck, .chReq,
      .srcValid, .srcData, .srcReady, .dstValid, .dstData, .dstReady);
   dirm_periph_model PM (.core_clk, .rstn, .addStb, .addCnt, .sinkOn, .stallOn,
      .srcValid, .srcData, .srcReady, .dstValid, .dstData, .dstReady);

   always #2.5 core_clk = ~core_clk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [4:0] expReq(input logic [11:0] sl, input logic [14:0] rx, tx);
      logic [3:0] q;
      expReq = '0;
      for (int k = 0; k < 3; k++) begin
         q = sl[4*k +: 4];
         if (q != 4'hF) begin
            expReq[2*k] = rx[q];
            if (k < 2) expReq[2*k+1] = tx[q];
         end
      end
   endfunction

   // Lower selectors are applied last so they win on equal values
   function automatic logic [29:0] expAck(input logic [11:0] sl, input logic [4:0] a);
      logic [3:0] q;
      logic [5:0] ax;
      ax = {1'b0, a};
      expAck = '0;
      for (int k = 2; k >= 0; k--) begin
         q = sl[4*k +: 4];
         if (q != 4'hF) begin
            expAck[q] = ax[2*k];
            expAck[15+q] = ax[2*k+1];
         end
      end
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmpCount++;
      if (g !== e) begin
         failCount++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic axw(input logic [31:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge core_clk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rsp = bresp;
   endtask

   task automatic axr(input logic [31:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge core_clk);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rsp = rresp;
   endtask

   task automatic feed(input logic [7:0] n);
      addCnt <= n;
      addStb <= 1'b1;
      @(posedge core_clk);
      addStb <= 1'b0;
   endtask

   task automatic waitGot(input int n);
      while (PM.gotQ.size() < n) @(posedge core_clk);
      repeat (4) @(posedge core_clk);
   endtask

   task automatic finalReport();
      $display("cmp=%0d fail=%0d", cmpCount, failCount);
      if (failCount == 0 && cmpCount > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         failCount++;
         finalReport();
      end
   end

   initial begin
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge core_clk);
      axr(A_MUX);
      chk(rd, 32'h00000FFF);
      axw(A_IDX, 32'h00001234);
      axr(A_IDX);
      chk(rd, 32'h00000000);
      axw(A_BAD, 32'h00000000);
      chk({30'h0, rsp}, {30'h0, dirm_pkg::RESP_SLVERR});
      axr(A_BAD);
      chk({30'h0, rsp}, {30'h0, dirm_pkg::RESP_SLVERR});
      // Every selector code on pair 0/1, equal selectors on odd passes
      for (int i = 0; i < 16; i++) begin
         r = rnd();
         s = {r[11:4], i[3:0]};
         if (i[0]) s[7:4] = s[3:0];
         axw(A_MUX, {20'h0, s});
         axr(A_MUX);
         chk(rd, {20'h0, s});
         r = rnd();
         perRxReq <= r[14:0];
         perTxReq <= r[30:16];
         r = rnd();
         chAck <= r[4:0];
         repeat (2) @(posedge core_clk);
         chk({27'h0, chReq}, {27'h0, expReq(s, perRxReq, perTxReq)});
         chk({2'h0, perTxAck, perRxAck}, {2'h0, expAck(s, chAck)});
      end
      perRxReq <= '0;
      perTxReq <= '0;
      chAck <= '0;
      // Fill the buffer with the sink stalled, then drain with stalls
      axw(A_LEN, 32'h00000010);
      axw(A_CTL, 32'h00000001);
      feed(8'h10);
      repeat (40) @(posedge core_clk);
      chk({31'h0, srcReady}, 32'h00000000);
      axr(A_IDX);
      chk(rd, 32'h00000000);
      sinkOn <= 1'b1;
      stallOn <= 1'b1;
      waitGot(16);
      axr(A_IDX);
      chk(rd, 32'h00000010);
      axr(A_CTL);
      chk(rd, 32'h00000000);
      axw(A_CTL, 32'h00000001);
      axr(A_IDX);
      chk(rd, 32'h00000000);
      axw(A_CTL, 32'h00000000);
      // Circular: three items over a length of two
      axw(A_LEN, 32'h00000002);
      axw(A_CTL, 32'h00000003);
      feed(8'h03);
      waitGot(19);
      axr(A_IDX);
      chk(rd, 32'h00000001);
      axr(A_CTL);
      chk(rd, 32'h00000003);
      axw(A_CTL, 32'h00000000);
      // Request-triggered: nothing moves until the mapped transmit request
      r = rnd();
      v = 4'(r % 15);
      axw(A_MUX, {20'h0, v, 8'hFF});
      axw(A_CTL, 32'h00000009);
      feed(8'h02);
      repeat (20) @(posedge core_clk);
      chk(PM.sentQ.size(), 32'h00000013);
      perTxReq[v] <= 1'b1;
      waitGot(21);
      axr(A_IDX);
      chk(rd, 32'h00000002);
      perTxReq <= '0;
      // Secure channel runs at once with its request mode forced off
      axw(A_CTL, 32'h0000000D);
      axr(A_CTL);
      chk(rd, 32'h00000005);
      feed(8'h02);
      waitGot(23);
      axr(A_IDX);
      chk(rd, 32'h00000002);
      chk(PM.gotQ.size(), 32'h00000017);
      for (int i = 0; i < 23; i++) begin
         chk(PM.gotQ[i], PM.sentQ[i]);
      end
      finalReport();
   end
endmodule
`default_nettype wire
